// File: rtl/dac_serial_input_port.v
// Three-wire serial input port: frame assembly, control decode and readback.
// What this block does
// - Each frame carries exactly one sixteen-bit word.
// - Top two bits control; rest are code.
// - Narrow variants use upper code bits only.
// - Sample on falling edge until rising selected.
// - Code 00 loads, 11 selects rising edge.
// - Edge-change frame does not load a code.
// - Only reset restores the falling-edge default.
// - Reset zeroes code and shift register.
// - Frame select is edge delimiter and enable.
// - Shift only while frame select is low.
// - Enable input buffers only during a frame.
// - Select rising after sixteen edges loads code.
// - Word travels most significant bit first.
// - Readback shifts old contents out rising edges.
`timescale 1ns/1ps
`include "dac_port_regs.vh"
module dac_serial_input_port #(
  parameter RES = `DEFAULT_RES
) (
  input  wire           core_clk_i,         // Core clock, 20 MHz.
  input  wire           rstn_i,             // Asynchronous reset, active low.
  input  wire           frame_sel_n_i,      // Frame select pin, active low.
  input  wire           serial_clk_i,       // Serial clock pin from the host.
  input  wire           serial_data_in_i,   // Serial data pin from the host.
  output reg            serial_data_out_o,  // Readback data toward the host.
  output wire [RES-1:0] dac_code_o,         // Code held for the converter core.
  output reg            edge_rising_o,      // High once rising-edge sampling chosen.
  output reg            port_active_o,      // Input buffers enabled.
  output reg            load_done_o,        // Strobe: code register updated.
  output reg            frame_reject_o      // Strobe: frame ended without effect.
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_FULL  = 2'h2;

  // Outcome of a frame once the select rises.
  localparam ACT_NONE   = 2'h0;
  localparam ACT_LOAD   = 2'h1;
  localparam ACT_EDGE   = 2'h2;
  localparam ACT_REJECT = 2'h3;

  wire                  frame_sel_n;
  wire                  sclk;
  wire                  data_level;
  reg                   frame_sel_n_d;
  reg                   sclk_d;
  reg  [1:0]            state;
  reg  [1:0]            next_state;
  reg  [`WORD_BITS-1:0] shift_word;
  reg  [`WORD_BITS-1:0] readback_word;
  reg  [`WORD_CNT_BITS-1:0] bit_count;
  reg                   load_strobe;
  wire                  frame_fall;
  wire                  frame_rise;
  wire                  sclk_rise;
  wire                  sclk_fall;
  wire                  active_edge;
  wire [1:0]            ctrl_code;
  reg  [`WORD_BITS-1:0] next_shift_word;
  reg  [`WORD_CNT_BITS-1:0] next_bit_count;
  reg  [`WORD_BITS-1:0] next_readback_word;
  reg                   next_data_out;
  reg  [1:0]            frame_action;
  reg                   next_edge_rising;
  reg                   next_load_strobe;
  reg                   next_frame_reject;

  // Filtered-level edge finder shared by the select and the serial clock.
  function edge_seen;
    input prev_level;
    input cur_level;
    input want_rise;
    begin
      if (want_rise) begin
        edge_seen = ~prev_level & cur_level;
      end else begin
        edge_seen = prev_level & ~cur_level;
      end
    end
  endfunction

  // A short word is refused before its control field is looked at.
  function [1:0] word_action;
    input       word_full;
    input [1:0] ctrl;
    begin
      if (!word_full) begin
        word_action = ACT_REJECT;
      end else begin
        case (ctrl)
          `CTRL_LOAD: begin
            word_action = ACT_LOAD;
          end
          `CTRL_RISE_EDGE: begin
            word_action = ACT_EDGE;
          end
          default: begin
            word_action = ACT_REJECT;
          end
        endcase
      end
    end
  endfunction

  pin_sync #(
    .RST_VAL (`RST_FRAME_SEL)
  ) u_sync_frame (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .pin_i      (frame_sel_n_i),
    .level_o    (frame_sel_n)
  );

  pin_sync #(
    .RST_VAL (`RST_SCLK_LEVEL)
  ) u_sync_clk (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .pin_i      (serial_clk_i),
    .level_o    (sclk)
  );

  pin_sync #(
    .RST_VAL (1'b0)
  ) u_sync_data (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .pin_i      (serial_data_in_i),
    .level_o    (data_level)
  );

  // Edge history of the filtered levels.
  // The clock history starts at the idle-high level, so leaving reset shows no false edge.
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_sel_n_d <= `RST_FRAME_SEL;
      sclk_d        <= `RST_SCLK_LEVEL;
    end else begin
      frame_sel_n_d <= frame_sel_n;
      sclk_d        <= sclk;
    end
  end

  assign frame_fall  = edge_seen(frame_sel_n_d, frame_sel_n, 1'b0);
  assign frame_rise  = edge_seen(frame_sel_n_d, frame_sel_n, 1'b1);
  assign sclk_rise   = edge_seen(sclk_d, sclk, 1'b1);
  assign sclk_fall   = edge_seen(sclk_d, sclk, 1'b0);
  assign active_edge = edge_rising_o ? sclk_rise : sclk_fall;
  assign ctrl_code   = {shift_word[`CTRL_HI_POS], shift_word[`CTRL_LO_POS]};

  // The frame state follows the select; a host that lowers the select late
  // loses the clock edges seen before it (the host must keep the setup).
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (frame_fall) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (frame_rise) begin
          next_state = ST_IDLE;
        end else if (active_edge && bit_count == `WORD_BITS - 1) begin
          next_state = ST_FULL;
        end
      end
      ST_FULL: begin
        if (frame_rise) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Buffers are on only between the select falling and rising.
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port_active_o <= 1'b0;
    end else if (frame_fall) begin
      port_active_o <= 1'b1;
    end else if (frame_rise) begin
      port_active_o <= 1'b0;
    end
  end

  // Input shift register, filled from the bottom so the first bit lands on top.
  // Edges beyond the sixteenth are ignored so the word cannot slip.
  always @* begin
    next_shift_word = shift_word;
    next_bit_count  = bit_count;
    if (frame_fall) begin
      next_bit_count = {`WORD_CNT_BITS{1'b0}};
    end else if (state == ST_SHIFT && !frame_sel_n && active_edge) begin
      next_shift_word = {shift_word[`WORD_BITS-2:0], data_level};
      next_bit_count  = bit_count + 1'b1;
    end
  end

  // The count stops at sixteen by state, so it never wraps inside a frame.
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_word <= `RST_WORD;
      bit_count  <= {`WORD_CNT_BITS{1'b0}};
    end else begin
      shift_word <= next_shift_word;
      bit_count  <= next_bit_count;
    end
  end

  // Readback copies the word at the frame start and presents it MSB first,
  // advancing on each rising serial clock edge inside the frame.
  always @* begin
    next_readback_word = readback_word;
    next_data_out      = serial_data_out_o;
    if (frame_fall) begin
      next_readback_word = {shift_word[`WORD_BITS-2:0], 1'b0};
      next_data_out      = shift_word[`WORD_BITS-1];
    end else if (!frame_sel_n && state != ST_IDLE && sclk_rise) begin
      next_readback_word = {readback_word[`WORD_BITS-2:0], 1'b0};
      next_data_out      = readback_word[`WORD_BITS-1];
    end
  end

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      readback_word     <= `RST_WORD;
      serial_data_out_o <= 1'b0;
    end else begin
      readback_word     <= next_readback_word;
      serial_data_out_o <= next_data_out;
    end
  end

  // Decode the completed word when the select rises.
  always @* begin
    frame_action      = ACT_NONE;
    next_edge_rising  = edge_rising_o;
    next_load_strobe  = 1'b0;
    next_frame_reject = 1'b0;
    if (frame_rise && state != ST_IDLE) begin
      frame_action = word_action(state == ST_FULL, ctrl_code);
    end
    case (frame_action)
      ACT_LOAD: begin
        next_load_strobe = 1'b1;
      end
      ACT_EDGE: begin
        next_edge_rising = 1'b1;
      end
      ACT_REJECT: begin
        next_frame_reject = 1'b1;
      end
      default: begin
        next_load_strobe = 1'b0;
      end
    endcase
  end

  // Registered copies keep every output straight from a flip-flop.
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      edge_rising_o  <= `RST_EDGE_RISE;
      load_strobe    <= 1'b0;
      load_done_o    <= 1'b0;
      frame_reject_o <= 1'b0;
    end else begin
      edge_rising_o  <= next_edge_rising;
      load_strobe    <= next_load_strobe;
      load_done_o    <= load_strobe;
      frame_reject_o <= next_frame_reject;
    end
  end

  dac_code_reg #(
    .RES (RES)
  ) u_code_reg (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .load_i     (load_strobe),
    .word_i     (shift_word),
    .code_o     (dac_code_o)
  );

endmodule

// File: rtl/dac_port_regs.vh
// Constants for the serial input port of the multiplying converter.
`ifndef DAC_PORT_REGS_VH
`define DAC_PORT_REGS_VH

// Word layout: one frame carries one word, control field on top.
`define WORD_BITS       16
`define WORD_CNT_BITS   5
`define CTRL_HI_POS     15
`define CTRL_LO_POS     14
`define CODE_TOP_POS    13

// Control field codes.
`define CTRL_LOAD       2'h0
`define CTRL_RSVD_A     2'h1
`define CTRL_RSVD_B     2'h2
`define CTRL_RISE_EDGE  2'h3

// Reset values.
`define RST_WORD        16'h0000
`define RST_EDGE_RISE   1'h0
`define RST_FRAME_SEL   1'h1
`define RST_SCLK_LEVEL  1'h1

// Default converter resolution and synchroniser depth.
`define DEFAULT_RES     14
`define SYNC_STAGES     3

`endif

// File: rtl/pin_sync.v
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire core_clk_i,  // Core clock.
  input  wire rstn_i,      // Asynchronous reset, active low.
  input  wire pin_i,       // Raw pin from outside the clock domain.
  output reg  level_o      // Filtered level in the core domain.
);

  reg stage1;
  reg stage2;
  reg stage3;

  // Stage one feeds stage two only; the filter looks at stages two and three.
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage1  <= RST_VAL;
      stage2  <= RST_VAL;
      stage3  <= RST_VAL;
      level_o <= RST_VAL;
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level_o <= stage3;
      end
    end
  end

endmodule

// File: rtl/dac_code_reg.v
// Converter code register loaded from the upper code bits of an accepted word.
`timescale 1ns/1ps
`include "dac_port_regs.vh"
module dac_code_reg #(
  parameter RES = `DEFAULT_RES
) (
  input  wire                  core_clk_i,  // Core clock.
  input  wire                  rstn_i,      // Asynchronous reset, active low.
  input  wire                  load_i,      // One-cycle load strobe.
  input  wire [`WORD_BITS-1:0] word_i,      // Completed input word.
  output reg  [RES-1:0]        code_o       // Code held for the converter core.
);

  // Narrow variants keep the upper code bits and drop the low positions.
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      code_o <= {RES{1'b0}};
    end else if (load_i) begin
      code_o <= word_i[`CODE_TOP_POS -: RES];
    end
  end

endmodule

// File: tb/dac_port_monitor.sv
// Concurrent checks on the outputs of the serial input port.
`timescale 1ns/1ps
module dac_port_monitor #(
  parameter RES = 14
) (
  input wire           core_clk_i,     // Core clock.
  input wire           rstn_i,         // Reset, active low.
  input wire           frame_sel_n_i,  // Frame select pin.
  input wire [RES-1:0] dac_code_o,     // Held code.
  input wire           edge_rising_o,  // Edge setting.
  input wire           port_active_o,  // Buffers enabled.
  input wire           load_done_o,    // Load strobe.
  input wire           frame_reject_o  // Reject strobe.
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  chk_load_single: assert property (load_done_o |=> !load_done_o)
    else $error("load strobe too long");
  chk_code_hold: assert property (!load_done_o |-> $stable(dac_code_o))
    else $error("code changed without load");
  chk_edge_sticky: assert property (edge_rising_o |=> edge_rising_o)
    else $error("edge setting dropped");
  chk_edge_no_load: assert property ($rose(edge_rising_o) |-> !load_done_o [*3])
    else $error("edge frame loaded a code");
  chk_load_after_sel: assert property (
    load_done_o |-> frame_sel_n_i && $past(frame_sel_n_i, 4))
    else $error("load without select rise");
  chk_idle_quiet: assert property (frame_sel_n_i [*7] |-> !port_active_o)
    else $error("port active while idle");
  chk_active_frame: assert property (!frame_sel_n_i [*8] |-> port_active_o)
    else $error("port inactive in frame");
  chk_reject_once: assert property (
    frame_reject_o |=> !frame_reject_o && !load_done_o)
    else $error("reject strobe wrong");
endmodule
bind dac_serial_input_port dac_port_monitor #(.RES(RES)) mon (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .frame_sel_n_i(frame_sel_n_i),
  .dac_code_o(dac_code_o), .edge_rising_o(edge_rising_o),
  .port_active_o(port_active_o), .load_done_o(load_done_o),
  .frame_reject_o(frame_reject_o));

// File: tb/serial_host.sv
// Host master model that drives frames onto the three-wire link.
`timescale 1ns/1ps
module serial_host (
  input  wire core_clk_i,  // Pacing clock.
  input  wire back_i,      // Readback bit.
  output reg  sel_n_o,     // Frame select, active low.
  output reg  sclk_o,      // Serial clock, idle high.
  output reg  sdi_o        // Serial data.
);
  initial begin
    sel_n_o = 1'b1;
    sclk_o  = 1'b1;
    sdi_o   = 1'b0;
  end
  task automatic wait_n(input integer n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // Sends the top n bits of w; each readback bit is taken just before the next bit.
  task automatic frame(input [15:0] w, input integer n, input rise, input split,
                       output [15:0] rd);
    integer i;
    rd = 16'h0000;
    sel_n_o <= 1'b0;
    wait_n(6);
    for (i = 0; i < n; i = i + 1) begin
      if (split && i == 8) wait_n(10);
      sclk_o <= !rise;
      sdi_o  <= w[15-i];
      wait_n(4);
      sclk_o <= rise;
      wait_n(3);
      @(negedge core_clk_i) rd = {rd[14:0], back_i};
      @(posedge core_clk_i);
    end
    sel_n_o <= 1'b1;
    sclk_o  <= 1'b1;
    sdi_o   <= ~sdi_o;
    wait_n(10);
  endtask
  // Clock and data activity while the port is not selected.
  task automatic idle_clocks;
    integer i;
    for (i = 0; i < 8; i = i + 1) begin
      sclk_o <= ~sclk_o;
      sdi_o  <= i[0];
      wait_n(4);
    end
  endtask
endmodule

// File: tb/tb_dac_serial_input_port.sv
// Self-checking bench for the serial input port with a result queue.
`timescale 1ns/1ps
module tb_dac_serial_input_port;
  localparam RES = 12;
  reg            core_clk_i, rstn_i, rise_mode, prev_edge;
  wire           sel_n, sclk, sdi, back, edge_rise, active, done, reject;
  wire [RES-1:0] code;
  reg  [1:0]     kind_q[$];
  reg  [RES-1:0] code_q[$];
  reg  [15:0]    sr, rd, w;
  integer        bad_count, checks, seed, i;
  serial_host host (.core_clk_i(core_clk_i), .back_i(back), .sel_n_o(sel_n),
    .sclk_o(sclk), .sdi_o(sdi));
  dac_serial_input_port #(.RES(RES)) uut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .frame_sel_n_i(sel_n), .serial_clk_i(sclk), .serial_data_in_i(sdi),
    .serial_data_out_o(back), .dac_code_o(code), .edge_rising_o(edge_rise),
    .port_active_o(active), .load_done_o(done), .frame_reject_o(reject));
  task automatic check(input ok, input [8*16-1:0] msg);
    checks = checks + 1;
    if (!ok) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %0t %0s", $time, msg);
    end
  endtask
  task print_verdict;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Notes the outcome a frame must have, then sends it.
  task automatic send(input [15:0] wd, input integer n, input split);
    reg [15:0] prev;
    prev = sr;
    if (n < 16 || wd[15:14] == 2'h1 || wd[15:14] == 2'h2) kind_q.push_back(2'h1);
    else kind_q.push_back(wd[15:14] == 2'h3 ? 2'h2 : 2'h0);
    code_q.push_back(wd[13 -: RES]);
    host.frame(wd, n, rise_mode, split, rd);
    sr = (sr << n) | (wd >> (16 - n));
    if (n == 16) check(rd === prev, "readback");
  endtask
  always @(negedge core_clk_i) if (rstn_i) begin
    if (done || reject || (edge_rise && !prev_edge)) begin
      if (kind_q.size() == 0) check(1'b0, "extra result");
      else begin
        check(kind_q[0] === (done ? 2'h0 : reject ? 2'h1 : 2'h2), "kind");
        if (done) check(code === code_q[0], "code");
        void'(kind_q.pop_front());
        void'(code_q.pop_front());
      end
    end
    prev_edge = edge_rise;
  end
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    bad_count = bad_count + 1;
    print_verdict;
  end
  initial begin
    rstn_i = 1'b0;
    bad_count = 0;
    checks = 0;
    seed = 501;
    sr = 16'h0000;
    rise_mode = 1'b0;
    prev_edge = 1'b0;
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    check(code === 0 && edge_rise === 1'b0, "reset state");
    for (i = 0; i < 12; i = i + 1) begin
      w = $random(seed);
      if (i < 8) w[15:14] = 2'h0;
      else w[15:14] = {w[15], ~w[15]};
      if (i == 3) host.idle_clocks();
      send(w, (i == 5) ? 10 : 16, i == 2);
    end
    send(16'hc000, 16, 1'b0);
    rise_mode = 1'b1;
    for (i = 0; i < 3; i = i + 1) begin
      w = $random(seed);
      w[15:14] = 2'h0;
      send(w, 16, 1'b0);
    end
    repeat (20) @(posedge core_clk_i);
    check(edge_rise === 1'b1 && kind_q.size() == 0, "final state");
    print_verdict;
  end
endmodule
